// file: torque_off_consts.svh
// Functional notes
// - Drive is permitted only while both torque-cut inputs stay high.
// - Either input low removes the gate-driver supply at once.
// - Input gating works apart from, and overrides, the processor drive request.
// - After a torque cut, no torque returns by itself, even after reset.
// - Function is off while the board jumper is fitted; removing it arms it.
// - Fault monitoring runs only when software sets the monitor enable bit.
// - After inputs return high, motor stays stopped until a fresh start command.
// - Without dedicated gating, general digital inputs one and two serve instead.
// - A torque-cut failure shows LED pattern 010, shared with voltage faults.
// - Undervoltage alongside a torque-cut fault is expected and treated as normal.
// - The gating path self-test runs after every power-on.
// - Self-test may also be started by command at any time.
// - A failed self-test stops switch drive, sets a flag, may drive an output.
// - Both inputs are sampled continuously every millisecond.
// - Input low while driver supply stays up sets the fault flag.
`ifndef TORQUE_OFF_CONSTS_SVH
`define TORQUE_OFF_CONSTS_SVH

`define CLK_PERIOD_NS      100
`define SAMPLE_TIME_NS     1000000
`define SAMPLE_CYCLES      (`SAMPLE_TIME_NS / `CLK_PERIOD_NS)
`define SETTLE_TIME_NS     100000
`define SETTLE_CYCLES      (`SETTLE_TIME_NS / `CLK_PERIOD_NS)

`define CTRL_OFFSET        8'h00
`define STATUS_OFFSET      8'h04
`define CTRL_RESET         32'h00000000

`define CTRL_MONITOR_BIT   0
`define CTRL_FAULTOUT_BIT  1
`define CTRL_START_BIT     2
`define CTRL_SELFTEST_BIT  3

`define ST_ACTIVE_BIT      0
`define ST_FAULT_BIT       1
`define ST_SWFAIL_BIT      2
`define ST_BUSY_BIT        3
`define ST_RUN_BIT         4
`define ST_INA_BIT         5
`define ST_INB_BIT         6
`define ST_JUMPER_BIT      7
`define ST_UNDERV_BIT      8
`define ST_OVERV_BIT       9
`define ST_SUPPLY_BIT      10

`define LED_IDLE           3'h0
`define LED_RUN            3'h1
`define LED_FAULT          3'h2

`endif

// file: torque_off_pkg.sv
package torque_off_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CUT,
        ST_SETTLE,
        ST_CHECK
    } selfTest_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wbReq_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wbRsp_s;

    typedef struct packed {
        logic        monitorEn;
        logic        faultOutEn;
        logic        stoFault;
        logic        switchFail;
        logic        runLatch;
        logic        pending;
        selfTest_e   phase;
        logic [15:0] sampleCnt;
        logic [15:0] settleCnt;
        logic        prevLow;
        logic        prevMismatch;
        logic        ack;
        logic [31:0] rdData;
        logic        gateEn;
        logic        switchEn;
        logic        faultOut;
        logic [2:0]  led;
    } supState_s;

endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } syncState_s;

    syncState_s       cur_r;
    syncState_s       cur_nxt;
    logic [WIDTH-1:0] agree;

    if (WIDTH < 1) begin : gWidthCheck
        $error("pin_sync needs at least one bit");
    end

    // Stage one feeds only stage two; the filter looks at stages two and three.
    assign agree = ~(cur_r.stage2 ^ cur_r.stage3);

    always_comb begin
        cur_nxt        = cur_r;
        cur_nxt.stage1 = pinIn;
        cur_nxt.stage2 = cur_r.stage1;
        cur_nxt.stage3 = cur_r.stage2;
        cur_nxt.level  = (cur_r.level & ~agree) | (cur_r.stage2 & agree);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign pinOut = cur_r.level;

endmodule

// file: torque_off_supervisor.sv
`timescale 1ns/1ps
`include "torque_off_consts.svh"
module torque_off_supervisor #(
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter bit HW_GATING     = 1'b1
) (
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire torque_off_pkg::wbReq_s wbReq,
    output torque_off_pkg::wbRsp_s      wbRsp,
    input  wire logic                   torqueCutInputA,
    input  wire logic                   torqueCutInputB,
    input  wire logic [1:0]             generalInput,
    input  wire logic                   jumperFitted,
    input  wire logic                   driverSupplyOk,
    input  wire logic                   undervoltageFlag,
    input  wire logic                   overvoltageFlag,
    input  wire logic                   motorDriveReq,
    output logic                        gateDriverSupplyEn,
    output logic                        powerSwitchEn,
    output logic                        faultOutput,
    output logic [2:0]                  statusLed
);
    import torque_off_pkg::*;

    localparam int SETTLE_CYCLES = `SETTLE_CYCLES;

    supState_s   cur_r;
    supState_s   cur_nxt;
    logic [7:0]  syncPins;
    logic        inA;
    logic        inB;
    logic        jumperIn;
    logic        supplyUp;
    logic        underIn;
    logic        overIn;
    logic        armed;
    logic        inHigh;
    logic        busReq;
    logic        wrCtrl;
    logic        wrStatus;
    logic        startWrite;
    logic        selfTestWrite;
    logic        faultClear;
    logic        swFailClear;
    logic        tick;
    logic        lowNow;
    logic        mismatchNow;
    logic        faultSet;
    logic        swFailSet;
    logic        stopRun;
    logic        gateNxt;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;

    if (SAMPLE_CYCLES < 16 || SAMPLE_CYCLES > 65535) begin : gSampleCheck
        $error("SAMPLE_CYCLES must lie between 16 and 65535");
    end
    if (SETTLE_CYCLES < 8 || SETTLE_CYCLES > 65535) begin : gSettleCheck
        $error("Settle count must lie between 8 and 65535");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Everything from the connector is asynchronous to mclk.

    pin_sync #(
        .WIDTH (8)
    ) uPinSync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pinIn   ({overvoltageFlag, undervoltageFlag, driverSupplyOk, jumperFitted,
                   generalInput, torqueCutInputB, torqueCutInputA}),
        .pinOut  (syncPins)
    );

    // Variants without the dedicated gating circuit take general inputs one and two.
    assign inA      = HW_GATING ? syncPins[0] : syncPins[2];
    assign inB      = HW_GATING ? syncPins[1] : syncPins[3];
    assign jumperIn = syncPins[4];
    assign supplyUp = syncPins[5];
    assign underIn  = syncPins[6];
    assign overIn   = syncPins[7];

    // A fitted jumper disarms the function; the synchroniser resets to "armed".
    assign armed  = !jumperIn;
    assign inHigh = inA && inB;

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave decode. One wait state: ack follows the request edge.

    assign busReq        = wbReq.cyc && wbReq.stb && !cur_r.ack;
    assign wrCtrl        = busReq && wbReq.we && wbReq.sel[0] && (wbReq.adr == `CTRL_OFFSET);
    assign wrStatus      = busReq && wbReq.we && wbReq.sel[0] && (wbReq.adr == `STATUS_OFFSET);
    assign startWrite    = wrCtrl && wbReq.dat[`CTRL_START_BIT];
    assign selfTestWrite = wrCtrl && wbReq.dat[`CTRL_SELFTEST_BIT];
    assign faultClear    = wrStatus && wbReq.dat[`ST_FAULT_BIT];
    assign swFailClear   = wrStatus && wbReq.dat[`ST_SWFAIL_BIT];

    always_comb begin
        ctrlWord                     = `CTRL_RESET;
        ctrlWord[`CTRL_MONITOR_BIT]  = cur_r.monitorEn;
        ctrlWord[`CTRL_FAULTOUT_BIT] = cur_r.faultOutEn;
    end

    always_comb begin
        statusWord                 = '0;
        statusWord[`ST_ACTIVE_BIT] = armed && !inHigh;
        statusWord[`ST_FAULT_BIT]  = cur_r.stoFault;
        statusWord[`ST_SWFAIL_BIT] = cur_r.switchFail;
        statusWord[`ST_BUSY_BIT]   = cur_r.phase != ST_IDLE;
        statusWord[`ST_RUN_BIT]    = cur_r.runLatch;
        statusWord[`ST_INA_BIT]    = inA;
        statusWord[`ST_INB_BIT]    = inB;
        statusWord[`ST_JUMPER_BIT] = jumperIn;
        statusWord[`ST_UNDERV_BIT] = underIn;
        statusWord[`ST_OVERV_BIT]  = overIn;
        statusWord[`ST_SUPPLY_BIT] = supplyUp;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Periodic input check.

    assign tick        = cur_r.sampleCnt == 16'h0000;
    assign lowNow      = !inHigh;
    assign mismatchNow = inA != inB;

    // Two consecutive low samples are needed, so the supply has a full period to
    // drain after a genuine cut and a slow rail never raises a false fault.
    // A lasting mismatch between the inputs is a wiring fault and is flagged too.
    assign faultSet = tick && cur_r.monitorEn && armed &&
                      ((lowNow && cur_r.prevLow && supplyUp) ||
                       (mismatchNow && cur_r.prevMismatch));

    assign swFailSet = (cur_r.phase == ST_CHECK) && supplyUp;

    // A cut, a self-test failure or a running or pending self-test drops the run latch, a set fault flag does not; only a start write sets it.
    assign stopRun = (armed && !inHigh) || cur_r.switchFail || swFailSet ||
                     (cur_r.phase != ST_IDLE) || cur_r.pending;

    ////////////////////////////////////////////////////////////////////////////////
    // State update.

    always_comb begin
        cur_nxt = cur_r;

        if (wrCtrl) begin
            cur_nxt.monitorEn  = wbReq.dat[`CTRL_MONITOR_BIT];
            cur_nxt.faultOutEn = wbReq.dat[`CTRL_FAULTOUT_BIT];
        end

        if (tick) begin
            cur_nxt.sampleCnt    = 16'(SAMPLE_CYCLES - 1);
            cur_nxt.prevLow      = lowNow;
            cur_nxt.prevMismatch = mismatchNow;
        end else begin
            cur_nxt.sampleCnt = cur_r.sampleCnt - 16'h0001;
        end

        // Hardware sets win over a software clear in the same cycle.
        cur_nxt.stoFault   = faultSet || (cur_r.stoFault && !faultClear);
        cur_nxt.switchFail = swFailSet || (cur_r.switchFail && !swFailClear);

        cur_nxt.pending = selfTestWrite;
        case (cur_r.phase)
            ST_IDLE: begin
                if (cur_r.pending) begin
                    cur_nxt.phase = ST_CUT;
                end else begin
                    cur_nxt.pending = selfTestWrite || cur_r.pending;
                end
            end
            ST_CUT: begin
                cur_nxt.pending   = selfTestWrite || cur_r.pending;
                cur_nxt.settleCnt = 16'(SETTLE_CYCLES - 1);
                cur_nxt.phase     = ST_SETTLE;
            end
            ST_SETTLE: begin
                cur_nxt.pending = selfTestWrite || cur_r.pending;
                if (cur_r.settleCnt == 16'h0000) begin
                    cur_nxt.phase = ST_CHECK;
                end else begin
                    cur_nxt.settleCnt = cur_r.settleCnt - 16'h0001;
                end
            end
            ST_CHECK: begin
                cur_nxt.pending = selfTestWrite || cur_r.pending;
                cur_nxt.phase   = ST_IDLE;
            end
            default: begin
                cur_nxt.phase = ST_IDLE;
            end
        endcase

        // The latch is cleared at reset, so torque never resumes unasked.
        if (stopRun) begin
            cur_nxt.runLatch = 1'b0;
        end else if (startWrite) begin
            cur_nxt.runLatch = 1'b1;
        end

        // The processor request is only ever masked here, never used to open the gate.
        gateNxt          = (!armed || inHigh) && (cur_nxt.phase == ST_IDLE);
        cur_nxt.gateEn   = gateNxt;
        cur_nxt.switchEn = motorDriveReq && gateNxt && cur_nxt.runLatch &&
                           !cur_nxt.switchFail;
        cur_nxt.faultOut = cur_r.faultOutEn && (cur_nxt.stoFault || cur_nxt.switchFail);

        // Undervoltage is expected while the driver rail is cut, so it only
        // shares the fault pattern and triggers nothing else.
        if (cur_nxt.stoFault || cur_nxt.switchFail || underIn || overIn) begin
            cur_nxt.led = `LED_FAULT;
        end else if (cur_nxt.runLatch) begin
            cur_nxt.led = `LED_RUN;
        end else begin
            cur_nxt.led = `LED_IDLE;
        end

        cur_nxt.ack = busReq;
        if (busReq && !wbReq.we && wbReq.adr == `CTRL_OFFSET) begin
            cur_nxt.rdData = ctrlWord;
        end else if (busReq && !wbReq.we && wbReq.adr == `STATUS_OFFSET) begin
            cur_nxt.rdData = statusWord;
        end else begin
            cur_nxt.rdData = 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur_r           <= '0;
            cur_r.pending   <= 1'b1;
            cur_r.sampleCnt <= 16'(SAMPLE_CYCLES - 1);
            cur_r.led       <= `LED_IDLE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign wbRsp.ack          = cur_r.ack;
    assign wbRsp.dat          = cur_r.rdData;
    assign gateDriverSupplyEn = cur_r.gateEn;
    assign powerSwitchEn      = cur_r.switchEn;
    assign faultOutput        = cur_r.faultOut;
    assign statusLed          = cur_r.led;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cbMain @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence seqCutSeen;
        armed && !inHigh;
    endsequence

    sequence seqLiveFault;
        tick && cur_r.monitorEn && armed && lowNow && cur_r.prevLow && supplyUp;
    endsequence

    AST_GATE_BOTH_HIGH: assert property (
        armed && inHigh && cur_r.phase == ST_IDLE && !cur_r.pending |=> gateDriverSupplyEn
    ) else $error("gate stayed off with both inputs high");

    AST_GATE_CUT: assert property (
        seqCutSeen |=> !gateDriverSupplyEn && !powerSwitchEn
    ) else $error("gate supply not removed on low input");

    AST_SWITCH_NEEDS_GATE: assert property (
        powerSwitchEn |-> gateDriverSupplyEn && $past(motorDriveReq)
    ) else $error("switch drive without gate supply or request");

    AST_NO_SELF_RESTART: assert property (
        !cur_r.runLatch && !startWrite |=> !cur_r.runLatch && !powerSwitchEn
    ) else $error("drive resumed without a start command");

    AST_JUMPER_DISARMS: assert property (
        !armed && cur_nxt.phase == ST_IDLE |=> gateDriverSupplyEn
    ) else $error("disarmed function still cut the gate supply");

    AST_MONITOR_GATE: assert property (
        $rose(cur_r.stoFault) |-> $past(cur_r.monitorEn)
    ) else $error("fault raised with monitoring off");

    AST_START_AFTER_RETURN: assert property (
        $rose(cur_r.runLatch) |-> $past(startWrite) && $past(inHigh || !armed)
    ) else $error("run latch set without fresh start");

    AST_LED_PATTERN: assert property (
        cur_r.stoFault |-> statusLed == `LED_FAULT
    ) else $error("fault not shown on status LED");

    AST_POWERON_TEST: assert property (
        $fell(sys_rst) |-> ##[1:3] cur_r.phase == ST_CUT
    ) else $error("power-on self-test did not start");

    AST_CMD_TEST: assert property (
        selfTestWrite && cur_r.phase == ST_IDLE && !cur_r.pending |=> ##1 cur_r.phase == ST_CUT
    ) else $error("commanded self-test did not start");

    AST_TEST_FAIL_STOPS: assert property (
        cur_r.phase == ST_CHECK && supplyUp |=> cur_r.switchFail && !powerSwitchEn
    ) else $error("failed self-test left switches driven");

    AST_SAMPLE_SPACING: assert property (
        tick |=> !tick [*8]
    ) else $error("sample ticks too close");

    AST_LIVE_FAULT: assert property (
        seqLiveFault |=> cur_r.stoFault ##1 statusLed == `LED_FAULT
    ) else $error("live supply with low input not flagged");

    AST_FAULT_STICKY: assert property (
        cur_r.stoFault && !faultClear |=> cur_r.stoFault
    ) else $error("fault flag cleared without software");

    AST_FAULT_CLEAR: assert property (
        faultClear && !faultSet |=> !cur_r.stoFault
    ) else $error("fault flag survived a clear");

    AST_MISMATCH_FAULT: assert property (
        tick && cur_r.monitorEn && armed && mismatchNow && cur_r.prevMismatch |=> cur_r.stoFault
    ) else $error("lasting input mismatch not flagged");

    AST_UNDERV_LED: assert property (
        underIn |=> statusLed == `LED_FAULT
    ) else $error("undervoltage not shown on status LED");

    AST_FAULT_OUTPUT: assert property (
        cur_r.faultOutEn && cur_r.stoFault && !faultClear |=> faultOutput
    ) else $error("fault output not driven");

    AST_SWFAIL_STICKY: assert property (
        cur_r.switchFail && !swFailClear |=> cur_r.switchFail
    ) else $error("self-test fail flag cleared without software");

    AST_SELFTEST_GATE_OFF: assert property (
        cur_r.phase != ST_IDLE |-> !gateDriverSupplyEn
    ) else $error("gate supply on during self-test");

    AST_START_REFUSED: assert property (
        startWrite && armed && !inHigh |=> !cur_r.runLatch
    ) else $error("start taken while an input is low");

endmodule

// file: safety_source.sv
`timescale 1ns/1ps
module safety_source (
    input  wire logic mclk,
    input  wire logic levelReq,
    input  wire logic splitReq,
    output logic      lineA,
    output logic      lineB
);
    // Both lines move on the same edge, so the pair disagrees only when a test asks for it.
    always @(posedge mclk) begin
        lineA <= levelReq;
        lineB <= levelReq ^ splitReq;
    end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "torque_off_consts.svh"
module testbench;
    import torque_off_pkg::*;
    localparam int SAMP  = 64;
    localparam int LIMIT = 20000;
    logic        mclk             = 1'b0;
    logic        sys_rst          = 1'b1;
    wbReq_s      wbReq            = '0;
    wbRsp_s      wbRsp;
    logic        lineA;
    logic        lineB;
    logic        levelReq         = 1'b1;
    logic        splitReq         = 1'b0;
    logic        jumperFitted     = 1'b0;
    logic        driverSupplyOk   = 1'b0;
    logic        supplyStuck      = 1'b0;
    logic        undervoltageFlag = 1'b0;
    logic        overvoltageFlag  = 1'b0;
    logic        motorDriveReq    = 1'b0;
    logic        gateDriverSupplyEn;
    logic        powerSwitchEn;
    logic        faultOutput;
    logic [2:0]  statusLed;
    logic [31:0] st;
    int          bad_count        = 0;
    int          n_checks         = 0;
    int          cycles           = 0;

    always #50 mclk = ~mclk;

    // The rail drains one cycle after the gate supply is cut, unless a test holds it up.
    always @(posedge mclk) driverSupplyOk <= supplyStuck | gateDriverSupplyEn;

    safety_source u_src (
        .mclk     (mclk),
        .levelReq (levelReq),
        .splitReq (splitReq),
        .lineA    (lineA),
        .lineB    (lineB)
    );

    torque_off_supervisor #(.SAMPLE_CYCLES(SAMP), .HW_GATING(1'b1)) u_dut (
        .mclk               (mclk),
        .sys_rst            (sys_rst),
        .wbReq              (wbReq),
        .wbRsp              (wbRsp),
        .torqueCutInputA    (lineA),
        .torqueCutInputB    (lineB),
        .generalInput       ({lineB, lineA}),
        .jumperFitted       (jumperFitted),
        .driverSupplyOk     (driverSupplyOk),
        .undervoltageFlag   (undervoltageFlag),
        .overvoltageFlag    (overvoltageFlag),
        .motorDriveReq      (motorDriveReq),
        .gateDriverSupplyEn (gateDriverSupplyEn),
        .powerSwitchEn      (powerSwitchEn),
        .faultOutput        (faultOutput),
        .statusLed          (statusLed)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        $display("ERROR t=%0t %s", $time, msg);
        bad_count++;
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) fail(what);
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) fail(what);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail("run did not finish in time");
            end_of_test();
        end
    end

    // Values read right after an edge are the ones the edge sampled, since the design
    // updates by non-blocking assignment.
    // Only the bench timeout ends a wait for the answer.
    task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        @(posedge mclk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wdat};
        do begin
            @(posedge mclk);
        end while (wbRsp.ack !== 1'b1);
        st = wbRsp.dat;
        wbReq <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        wbCycle(1'b1, adr, d);
    endtask

    task automatic rd(input logic [7:0] adr);
        wbCycle(1'b0, adr, 32'h00000000);
    endtask

    task automatic waitCyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic waitTest();
        int n;
        n = 0;
        waitCyc(4);
        do begin
            rd(`STATUS_OFFSET);
            n++;
        end while (st[`ST_BUSY_BIT] !== 1'b0 && n < 600);
        if (n >= 600) fail("self-test never ended");
    endtask

    task automatic doReset();
        sys_rst <= 1'b1;
        waitCyc(20);
        chkBit(gateDriverSupplyEn, 1'b0, "gate on in reset");
        chkBit(powerSwitchEn, 1'b0, "switch on in reset");
        sys_rst <= 1'b0;
        waitCyc(4);
        chkBit(gateDriverSupplyEn, 1'b0, "gate on during self-test");
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_BUSY_BIT], 1'b1, "no self-test at power-on");
        waitTest();
        chkBit(st[`ST_SWFAIL_BIT], 1'b0, "good self-test failed");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        doReset();
        rd(`CTRL_OFFSET);
        chkWord(st, `CTRL_RESET, "control reset value");
        wr(`CTRL_OFFSET, 32'h00000003);
        rd(`CTRL_OFFSET);
        chkWord(st, 32'h00000003, "control readback");
        wr(8'h10, 32'hffffffff);
        rd(8'h10);
        chkWord(st, 32'h00000000, "unmapped read");
        motorDriveReq <= 1'b1;
        waitCyc(4);
        chkBit(powerSwitchEn, 1'b0, "drive without start");
        wr(`CTRL_OFFSET, 32'h00000007);
        waitCyc(3);
        chkBit(gateDriverSupplyEn, 1'b1, "gate off with inputs high");
        chkBit(powerSwitchEn, 1'b1, "no drive after start");
        levelReq <= 1'b0;
        waitCyc(8);
        chkBit(gateDriverSupplyEn, 1'b0, "gate on with inputs low");
        chkBit(powerSwitchEn, 1'b0, "request overrides cut");
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_ACTIVE_BIT], 1'b1, "cut not shown active");
        chkBit(st[`ST_INA_BIT], 1'b0, "input level not seen");
        waitCyc(3 * SAMP);
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_FAULT_BIT], 1'b0, "fault with rail down");
        levelReq <= 1'b1;
        waitCyc(8);
        chkBit(gateDriverSupplyEn, 1'b1, "gate stays off");
        chkBit(powerSwitchEn, 1'b0, "restart without start");
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_ACTIVE_BIT], 1'b0, "still active after release");
        chkBit(st[`ST_FAULT_BIT], 1'b0, "fault after release");
        wr(`CTRL_OFFSET, 32'h00000007);
        waitCyc(3);
        chkBit(powerSwitchEn, 1'b1, "no drive after restart");
        // Rail held up with inputs low: only the monitor enable decides the outcome.
        wr(`CTRL_OFFSET, 32'h00000000);
        supplyStuck <= 1'b1;
        levelReq <= 1'b0;
        waitCyc(3 * SAMP + 8);
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_FAULT_BIT], 1'b0, "fault with monitor off");
        wr(`CTRL_OFFSET, 32'h00000007);
        waitCyc(3 * SAMP);
        rd(`STATUS_OFFSET);
        chkBit(powerSwitchEn, 1'b0, "start taken while cut");
        chkBit(st[`ST_FAULT_BIT], 1'b1, "stuck rail not flagged");
        chkBit(faultOutput, 1'b1, "fault output off");
        chkWord({29'h0, statusLed}, {29'h0, `LED_FAULT}, "led pattern");
        undervoltageFlag <= 1'b1;
        overvoltageFlag <= 1'b1;
        levelReq <= 1'b1;
        supplyStuck <= 1'b0;
        waitCyc(10);
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_UNDERV_BIT], 1'b1, "undervoltage not shown");
        chkBit(st[`ST_OVERV_BIT], 1'b1, "overvoltage not shown");
        chkBit(st[`ST_FAULT_BIT], 1'b1, "fault not sticky");
        undervoltageFlag <= 1'b0;
        overvoltageFlag <= 1'b0;
        wr(`STATUS_OFFSET, 32'h00000002);
        waitCyc(2);
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_FAULT_BIT], 1'b0, "fault not cleared");
        chkBit(faultOutput, 1'b0, "fault output stuck");
        splitReq <= 1'b1;
        waitCyc(8);
        chkBit(gateDriverSupplyEn, 1'b0, "gate on with one input low");
        waitCyc(3 * SAMP);
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_FAULT_BIT], 1'b1, "mismatch not flagged");
        splitReq <= 1'b0;
        waitCyc(8);
        wr(`STATUS_OFFSET, 32'h00000002);
        // A rail that never drops makes the commanded self-test fail.
        supplyStuck <= 1'b1;
        wr(`CTRL_OFFSET, 32'h0000000b);
        waitTest();
        chkBit(st[`ST_SWFAIL_BIT], 1'b1, "self-test fail missed");
        chkBit(faultOutput, 1'b1, "fail output off");
        wr(`CTRL_OFFSET, 32'h00000007);
        waitCyc(3);
        chkBit(powerSwitchEn, 1'b0, "drive after failed test");
        supplyStuck <= 1'b0;
        wr(`STATUS_OFFSET, 32'h00000004);
        wr(`CTRL_OFFSET, 32'h00000007);
        waitCyc(3);
        chkBit(powerSwitchEn, 1'b1, "no drive after clear");
        jumperFitted <= 1'b1;
        levelReq <= 1'b0;
        waitCyc(10);
        chkBit(gateDriverSupplyEn, 1'b1, "inputs act while disarmed");
        rd(`STATUS_OFFSET);
        chkBit(st[`ST_JUMPER_BIT], 1'b1, "jumper not shown");
        chkBit(st[`ST_ACTIVE_BIT], 1'b0, "active while disarmed");
        wr(`CTRL_OFFSET, 32'h00000000);
        rd(`CTRL_OFFSET);
        chkWord(st, 32'h00000000, "monitor still enabled");
        jumperFitted <= 1'b0;
        levelReq <= 1'b1;
        doReset();
        waitCyc(4);
        chkBit(powerSwitchEn, 1'b0, "drive returns after reset");
        end_of_test();
    end
endmodule
